// >>> src/efp_consts.vh
// constants for the earth fault protection stage
// Notes on behaviour
// - stage supervises one selected residual input
// - modes resistive/capacitive, sector, undirectional
// - sector trips within half sector, default 88
// - angle offset applies to directional modes
// - submode fixed or from digital/virtual input
// - fixed delay used only in definite time
// - inverse delay scaled by multiplier
// - user curve from multiplier and three constants
// - residual voltage pickup and measurement in percent
// - settings need password except record/input select, forceables need force flag
// - keep eight latest fault records
// - record elapsed delay percent, 100 is trip
// - record max fault current and setting group
// - start when residual exceeds pickup
// - trip when start outlasts operate delay
// - short fault gives start without trip
// - restart within intermittent time keeps accumulation
// - report pickup in primary amperes
// - undirectional ignores angle and voltage threshold
`ifndef EFP_CONSTS_VH
`define EFP_CONSTS_VH
`define EFP_A_CTRL 12'h000
`define EFP_A_PICKUP 12'h004
`define EFP_A_UPICK 12'h008
`define EFP_A_ANGLE 12'h00c
`define EFP_A_DELAY 12'h010
`define EFP_A_MULT 12'h014
`define EFP_A_INTRMT 12'h018
`define EFP_A_CTRATIO 12'h01c
`define EFP_A_CURVEA 12'h020
`define EFP_A_CURVEB 12'h024
`define EFP_A_KEY 12'h040
`define EFP_A_FORCE 12'h044
`define EFP_A_STATUS 12'h048
`define EFP_A_MEAS 12'h04c
`define EFP_A_PRIM 12'h050
`define EFP_A_RECSEL 12'h054
`define EFP_A_RECCUR 12'h058
`define EFP_A_RECINFO 12'h05c
`define EFP_A_RECTIME 12'h060
`define EFP_PASSWORD 32'h0000a5c3
`define EFP_SECTOR_DEF 8'h58
`define EFP_CTRL_RST 32'h00000000
`define EFP_MODE_RC 2'h0
`define EFP_MODE_SEC 2'h1
`define EFP_MODE_UND 2'h2
`define EFP_SUB_RES 3'h0
`define EFP_SUB_CAP 3'h1
`define EFP_SUB_DI 3'h2
`define EFP_SUB_VI 3'h3
`define EFP_TYPE_DT 2'h0
`define EFP_TYPE_INV 2'h1
`define EFP_TYPE_USR 2'h2
`define EFP_TICK_US 1000
`define EFP_CLK_MHZ 10
`define EFP_TICK_CYC (`EFP_TICK_US * `EFP_CLK_MHZ)
`define EFP_NREC 8
`endif

// >>> src/efp_stage.v
// earth fault protection stage with apb settings and fault log
`timescale 1ns/100ps
`include "efp_consts.vh"
module efp_stage #(
  parameter TICK_CYC = `EFP_TICK_CYC
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  input wire [15:0] i_res1,
  input wire [15:0] i_res2,
  input wire [15:0] i_sum,
  input wire [15:0] i_res1_peak,
  input wire [15:0] i_res2_peak,
  input wire [15:0] i_uo,
  input wire signed [15:0] i_angle,
  input wire i_sub_di,
  input wire i_sub_vi,
  input wire [1:0] i_setting_group,
  input wire [47:0] i_timestamp,
  output reg o_start,
  output reg o_trip
);
  // ctrl: [2:0] unused, input comes from recsel [4:3] mode [7:5] submode ctrl [9:8] type [10] peak for inputs 3 and 4
  reg [31:0] ctrl_ff;
  reg [31:0] pick_ff;
  reg [31:0] upick_ff;
  reg [31:0] angle_ff;
  reg [31:0] delay_ff;
  reg [31:0] mult_ff;
  reg [31:0] intr_ff;
  reg [31:0] ratio_ff;
  reg [31:0] ca_ff;
  reg [31:0] cb_ff;
  reg unlock_ff;
  reg force_ff;
  reg fstart_ff;
  reg ftrip_ff;
  reg [2:0] sel_ff;
  // two flop synchronisers for every measurement and submode pin input
  reg [15:0] r1a_ff;
  reg [15:0] r1b_ff;
  reg [15:0] r2a_ff;
  reg [15:0] r2b_ff;
  reg [15:0] sma_ff;
  reg [15:0] smb_ff;
  reg [15:0] p1a_ff;
  reg [15:0] p1b_ff;
  reg [15:0] p2a_ff;
  reg [15:0] p2b_ff;
  reg [15:0] ua_ff;
  reg [15:0] ub_ff;
  reg [15:0] aa_ff;
  reg [15:0] ab_ff;
  reg dia_ff;
  reg dib_ff;
  reg via_ff;
  reg vib_ff;
  reg [15:0] tick_ff;
  reg [31:0] acc_ff;
  reg [31:0] gap_ff;
  reg [15:0] maxi_ff;
  reg infault_ff;
  reg trip_ff;
  reg [2:0] wp_ff;
  // records carry no reset; an unwritten slot reads unknown
  reg [15:0] rcur [0:7];
  reg [7:0] rpct [0:7];
  reg [1:0] rgrp [0:7];
  reg [47:0] rtime [0:7];
  reg [15:0] ruo [0:7];
  reg [15:0] maxu_ff;

  wire [1:0] mode = ctrl_ff[4:3];
  wire [2:0] subc = ctrl_ff[7:5];
  wire [1:0] dtype = ctrl_ff[9:8];
  wire wr = i_psel & i_penable & i_pwrite & i_ce;
  assign o_pready = 1'b1;

  function [15:0] absdiff;
    input signed [15:0] a;
    input signed [15:0] b;
    reg signed [16:0] d;
    begin
      d = {a[15], a} - {b[15], b};
      absdiff = d[16] ? (16'h0 - d[15:0]) : d[15:0];
    end
  endfunction

  // decode of known addresses, unknown ones give slverr
  function known;
    input [11:0] a;
    begin
      known = (a <= `EFP_A_CURVEB) || (a >= `EFP_A_KEY && a <= `EFP_A_RECTIME);
      known = known & (a[1:0] == 2'h0);
    end
  endfunction
  assign o_pslverr = i_psel & i_penable & ~known(i_paddr);

  reg [15:0] meas;
  always @* begin
    case (sel_ff)
      3'h0: meas = r1b_ff;
      3'h1: meas = r2b_ff;
      3'h2: meas = smb_ff;
      3'h3: meas = ctrl_ff[10] ? p1b_ff : r1b_ff;
      3'h4: meas = ctrl_ff[10] ? p2b_ff : r2b_ff;
      default: meas = r1b_ff;
    endcase
  end

  // active submode: 0 res, 1 cap, 2 none
  reg [1:0] act;
  always @* begin
    if (mode != `EFP_MODE_RC) begin
      act = 2'h2;
    end else begin
      case (subc)
        `EFP_SUB_RES: act = 2'h0;
        `EFP_SUB_CAP: act = 2'h1;
        `EFP_SUB_DI: act = {1'b0, dib_ff};
        `EFP_SUB_VI: act = {1'b0, vib_ff};
        default: act = 2'h0;
      endcase
    end
  end

  // direction: resistive looks around offset, capacitive around offset-90 (angle in degrees)
  wire signed [15:0] off = angle_ff[15:0];
  wire [15:0] half = {8'h00, angle_ff[23:16]};
  wire signed [15:0] capref = off - 16'sd90;
  reg dir_ok;
  always @* begin
    case (mode)
      `EFP_MODE_RC: dir_ok = absdiff(ab_ff, act[0] ? capref : off) < 16'd90;
      `EFP_MODE_SEC: dir_ok = absdiff(ab_ff, off) <= half;
      default: dir_ok = 1'b1;
    endcase
  end
  wire u_ok = (mode == `EFP_MODE_UND) | (ub_ff >= upick_ff[15:0]);
  // inputs are already fundamental-filtered by the channel, harmonic rejection lives there
  wire pick = (meas > pick_ff[15:0]) & dir_ok & u_ok;

  // inverse: limit = mult * 1000 / excess over pickup + 1, simplified integer form
  wire [15:0] excess = (meas > pick_ff[15:0]) ? meas - pick_ff[15:0] : 16'h0001;
  wire [31:0] inv_lim = (mult_ff[15:0] * 32'd1000) / {16'h0, excess} + 32'd1;
  wire [31:0] usr_lim = (mult_ff[15:0] * ca_ff[15:0]) / ({16'h0, excess} + cb_ff[15:0]) + cb_ff[31:16];
  reg [31:0] lim;
  always @* begin
    case (dtype)
      `EFP_TYPE_DT: lim = delay_ff;
      `EFP_TYPE_INV: lim = inv_lim;
      default: lim = usr_lim;
    endcase
  end
  wire tick = (tick_ff == TICK_CYC - 1);
  wire st = force_ff ? fstart_ff : pick;
  wire [31:0] lim_nz = (lim == 32'h0) ? 32'h1 : lim;
  wire [31:0] pct_w = (acc_ff * 32'd100) / lim_nz;
  wire [7:0] pct = (pct_w > 32'd100) ? 8'd100 : pct_w[7:0];

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      r1a_ff <= 16'h0;
      r1b_ff <= 16'h0;
      r2a_ff <= 16'h0;
      r2b_ff <= 16'h0;
      sma_ff <= 16'h0;
      smb_ff <= 16'h0;
      p1a_ff <= 16'h0;
      p1b_ff <= 16'h0;
      p2a_ff <= 16'h0;
      p2b_ff <= 16'h0;
      ua_ff <= 16'h0;
      ub_ff <= 16'h0;
      aa_ff <= 16'h0;
      ab_ff <= 16'h0;
      dia_ff <= 1'b0;
      dib_ff <= 1'b0;
      via_ff <= 1'b0;
      vib_ff <= 1'b0;
    end else if (i_ce) begin
      // channel samples come from another domain, only the second flop is read
      r1a_ff <= i_res1;
      r1b_ff <= r1a_ff;
      r2a_ff <= i_res2;
      r2b_ff <= r2a_ff;
      sma_ff <= i_sum;
      smb_ff <= sma_ff;
      p1a_ff <= i_res1_peak;
      p1b_ff <= p1a_ff;
      p2a_ff <= i_res2_peak;
      p2b_ff <= p2a_ff;
      ua_ff <= i_uo;
      ub_ff <= ua_ff;
      aa_ff <= i_angle;
      ab_ff <= aa_ff;
      dia_ff <= i_sub_di;
      dib_ff <= dia_ff;
      via_ff <= i_sub_vi;
      vib_ff <= via_ff;
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_ff <= `EFP_CTRL_RST;
      pick_ff <= 32'h0;
      upick_ff <= 32'h0;
      angle_ff <= {8'h00, `EFP_SECTOR_DEF, 16'h0};
      delay_ff <= 32'h0;
      mult_ff <= 32'h0;
      intr_ff <= 32'h0;
      ratio_ff <= 32'h0;
      ca_ff <= 32'h0;
      cb_ff <= 32'h0;
      unlock_ff <= 1'b0;
      force_ff <= 1'b0;
      fstart_ff <= 1'b0;
      ftrip_ff <= 1'b0;
      sel_ff <= 3'h0;
    end else if (wr) begin
      if (i_paddr == `EFP_A_KEY) unlock_ff <= (i_pwdata == `EFP_PASSWORD);
      // record select needs no password, it steers record reads and the measured input
      if (i_paddr == `EFP_A_RECSEL) sel_ff <= i_pwdata[2:0];
      if (unlock_ff) begin
        case (i_paddr)
          `EFP_A_CTRL: ctrl_ff <= i_pwdata;
          `EFP_A_PICKUP: pick_ff <= i_pwdata;
          `EFP_A_UPICK: upick_ff <= i_pwdata;
          `EFP_A_ANGLE: angle_ff <= i_pwdata;
          `EFP_A_DELAY: delay_ff <= i_pwdata;
          `EFP_A_MULT: mult_ff <= i_pwdata;
          `EFP_A_INTRMT: intr_ff <= i_pwdata;
          `EFP_A_CTRATIO: ratio_ff <= i_pwdata;
          `EFP_A_CURVEA: ca_ff <= i_pwdata;
          `EFP_A_CURVEB: cb_ff <= i_pwdata;
          `EFP_A_FORCE: force_ff <= i_pwdata[0];
          default: ;
        endcase
      end
      if (i_paddr == `EFP_A_STATUS && force_ff) begin
        fstart_ff <= i_pwdata[0];
        ftrip_ff <= i_pwdata[1];
      end
    end
  end

  // delay accumulator in ms ticks; gap counter holds accumulation between starts
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      tick_ff <= 16'h0;
      acc_ff <= 32'h0;
      gap_ff <= 32'h0;
      trip_ff <= 1'b0;
      infault_ff <= 1'b0;
      maxi_ff <= 16'h0;
      maxu_ff <= 16'h0;
      wp_ff <= 3'h0;
      o_start <= 1'b0;
      o_trip <= 1'b0;
    end else if (i_ce) begin
      tick_ff <= tick ? 16'h0 : tick_ff + 16'h1;
      // force mode bypasses pick so a test can drive the outputs
      o_start <= st;
      // outside force mode trip is masked by start so both outputs fall on the same edge
      o_trip <= force_ff ? ftrip_ff : (trip_ff & st);
      if (st) begin
        gap_ff <= 32'h0;
        infault_ff <= 1'b1;
        if (meas > maxi_ff) maxi_ff <= meas;
        if (ub_ff > maxu_ff) maxu_ff <= ub_ff;
        if (tick && !trip_ff) acc_ff <= acc_ff + 32'h1;
        if (acc_ff >= lim_nz) trip_ff <= 1'b1;
      end else begin
        trip_ff <= 1'b0;
        if (tick) begin
          if (gap_ff >= intr_ff) acc_ff <= 32'h0;
          else gap_ff <= gap_ff + 32'h1;
        end
        if (infault_ff) begin
          infault_ff <= 1'b0;
          rcur[wp_ff] <= maxi_ff;
          rpct[wp_ff] <= trip_ff ? 8'd100 : pct;
          rgrp[wp_ff] <= i_setting_group;
          rtime[wp_ff] <= i_timestamp;
          ruo[wp_ff] <= maxu_ff;
          wp_ff <= wp_ff + 3'h1;
          maxi_ff <= 16'h0;
          maxu_ff <= 16'h0;
        end
      end
    end
  end

  // record 0 is the latest fault
  wire [2:0] ri = wp_ff - 3'h1 - sel_ff;
  wire [47:0] prim = pick_ff[15:0] * ratio_ff[31:0];
  reg [31:0] rd_mux;
  always @* begin
    case (i_paddr)
      `EFP_A_CTRL: rd_mux = ctrl_ff;
      `EFP_A_PICKUP: rd_mux = pick_ff;
      `EFP_A_UPICK: rd_mux = upick_ff;
      `EFP_A_ANGLE: rd_mux = angle_ff;
      `EFP_A_DELAY: rd_mux = delay_ff;
      `EFP_A_MULT: rd_mux = mult_ff;
      `EFP_A_INTRMT: rd_mux = intr_ff;
      `EFP_A_CTRATIO: rd_mux = ratio_ff;
      `EFP_A_CURVEA: rd_mux = ca_ff;
      `EFP_A_CURVEB: rd_mux = cb_ff;
      `EFP_A_KEY: rd_mux = {31'h0, unlock_ff};
      `EFP_A_FORCE: rd_mux = {31'h0, force_ff};
      `EFP_A_STATUS: rd_mux = {20'h0, pct, act, o_trip, o_start};
      `EFP_A_MEAS: rd_mux = {ub_ff, meas};
      `EFP_A_PRIM: rd_mux = prim[31:0];
      `EFP_A_RECSEL: rd_mux = {29'h0, sel_ff};
      `EFP_A_RECCUR: rd_mux = {ruo[ri], rcur[ri]};
      `EFP_A_RECINFO: rd_mux = {22'h0, rgrp[ri], rpct[ri]};
      `EFP_A_RECTIME: rd_mux = rtime[ri][31:0];
      default: rd_mux = 32'h0;
    endcase
  end

  // read data captured in the setup cycle so it stands through the zero-wait access
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0;
    end else if (i_ce && i_psel && !i_penable) begin
      o_prdata <= rd_mux;
    end
  end
endmodule // efp_stage

// >>> verif/efp_stage_monitor.sv
// port checker for the earth fault protection stage
`timescale 1ns/100ps
module efp_stage_monitor #(
  parameter TICK_CYC = 10
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_psel,
  input wire i_penable,
  input wire [11:0] i_paddr,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_start,
  input wire o_trip
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire acc = i_psel && i_penable;
  wire mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= 12'h024 || (i_paddr >= 12'h040 && i_paddr <= 12'h060));
  a_ready_zero_wait: assert property (acc |-> o_pready) else $error("pready low in access phase");
  a_err_only_access: assert property (!acc |-> !o_pslverr) else $error("pslverr outside access phase");
  a_err_mapped_ok: assert property (acc && mapped |-> !o_pslverr) else $error("pslverr on mapped address");
  a_reset_clears_out: assert property ($fell(i_sys_rst) |-> !o_start && !o_trip) else $error("output set after reset");
  a_trip_needs_start: assert property (o_trip |-> o_start) else $error("trip without start");
  a_trip_after_start: assert property ($rose(o_trip) |-> $past(o_start)) else $error("trip rose before start");
  a_freeze_without_ce: assert property (!i_ce |=> $stable(o_start) && $stable(o_trip)) else $error("outputs moved with ce low");
  a_start_needs_ce: assert property ($rose(o_start) |-> $past(i_ce)) else $error("start rose with ce low");
  c_start: cover property ($rose(o_start));
  c_trip: cover property ($rose(o_trip));
  c_slverr: cover property (acc && o_pslverr);
endmodule // efp_stage_monitor
bind efp_stage efp_stage_monitor #(.TICK_CYC(TICK_CYC)) i_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
  .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_start(o_start), .o_trip(o_trip));

// >>> verif/efp_meas_model.sv
// behavioural model of the transformer measurement channels
`timescale 1ns/100ps
module efp_meas_model (
  input wire i_clk,
  input wire i_fault,
  input wire [15:0] i_level,
  output logic [15:0] o_res1,
  output logic [15:0] o_res2,
  output logic [15:0] o_sum,
  output logic [15:0] o_peak,
  output logic [15:0] o_uo,
  output logic signed [15:0] o_angle
);
  // idle channels carry a small standing residual, not zero, so a wrong select shows
  always @(posedge i_clk) begin
    o_res1 <= i_fault ? i_level : 16'h0008;
    o_res2 <= 16'h0004;
    o_sum <= 16'h000c;
    o_peak <= 16'h0002;
    // no voltage and a reversed angle: only an undirectional stage may start
    o_uo <= 16'h0000;
    o_angle <= 16'sh00b4;
  end
endmodule // efp_meas_model

// >>> verif/test_earth_fault_protection_stage.sv
// self-checking bench for the earth fault protection stage
`timescale 1ns/100ps
`include "efp_consts.vh"
module test_earth_fault_protection_stage;
  localparam TK = 10;
  logic i_clk = 0, i_sys_rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, fault = 0, sub_di = 0, sub_vi = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [15:0] level = 16'h0000;
  logic err, start_seen = 0, trip_seen = 0;
  wire [15:0] res1, res2, sum, peak, uo;
  wire signed [15:0] ang;
  wire pready, perr, start, trip;
  wire [31:0] prdata;
  int fails = 0, n_compared = 0, cyc = 0;
  initial forever #50 i_clk = ~i_clk;
  efp_meas_model i_meas (.i_clk(i_clk), .i_fault(fault), .i_level(level), .o_res1(res1), .o_res2(res2),
    .o_sum(sum), .o_peak(peak), .o_uo(uo), .o_angle(ang));
  efp_stage #(.TICK_CYC(TK)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(perr), .i_res1(res1), .i_res2(res2), .i_sum(sum), .i_res1_peak(peak), .i_res2_peak(peak),
    .i_uo(uo), .i_angle(ang), .i_sub_di(sub_di), .i_sub_vi(sub_vi), .i_setting_group(2'h1),
    .i_timestamp({16'h0000, cyc}), .o_start(start), .o_trip(trip));
  task automatic complete_run();
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) start_seen <= 1'b1;
    if (trip === 1'b1) trip_seen <= 1'b1;
    if (cyc == 20000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    pen <= 1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 0; pen <= 0;
  endtask
  task automatic t_reset();
    apb(0, `EFP_A_ANGLE, 32'h0); chk("angle", 32'h00580000, rd);
    apb(0, `EFP_A_STATUS, 32'h0); chk("status", 32'h0, rd);
    ce <= 0;
    repeat (3) @(posedge i_clk);
    ce <= 1;
  endtask
  task automatic t_lock();
    apb(1, `EFP_A_PICKUP, 32'h64); apb(0, `EFP_A_PICKUP, 32'h0); chk("locked", 32'h0, rd);
    apb(1, `EFP_A_KEY, `EFP_PASSWORD);
    apb(1, `EFP_A_PICKUP, 32'h64); apb(0, `EFP_A_PICKUP, 32'h0); chk("pickup", 32'h64, rd);
    apb(1, `EFP_A_STATUS, 32'h3); apb(0, `EFP_A_STATUS, 32'h0); chk("unforced", 32'h0, rd[1:0]);
    apb(0, 12'h0f0, 32'h0); chk("slverr", 32'h1, err);
  endtask
  task automatic t_sub();
    logic [2:0] sc [7] = '{0, 1, 2, 2, 3, 0, 0};
    logic [1:0] md [7] = '{0, 0, 0, 0, 0, 1, 2};
    logic [1:0] ex [7] = '{0, 1, 1, 0, 1, 2, 2};
    for (int k = 0; k < 7; k++) begin
      sub_di <= (k == 2);
      sub_vi <= (k == 4);
      apb(1, `EFP_A_CTRL, {24'h0, sc[k], md[k], 3'h0});
      apb(0, `EFP_A_STATUS, 32'h0); chk("submode", ex[k], rd[3:2]);
    end
  endtask
  task automatic t_trip();
    apb(1, `EFP_A_CTRL, 32'h10);
    apb(1, `EFP_A_UPICK, 32'h32);
    apb(1, `EFP_A_DELAY, 32'h3);
    apb(1, `EFP_A_CTRATIO, 32'h5);
    apb(0, `EFP_A_PRIM, 32'h0); chk("primary", 32'h1f4, rd);
    fault <= 1;
    level <= 16'h00c8;
    trip_seen <= 0;
    repeat (8) @(posedge i_clk);
    chk("start", 32'h1, start);
    // earliest trip is three ticks after start less one tick of phase
    repeat (2 * TK - 6) @(posedge i_clk);
    chk("early_trip", 32'h0, trip_seen);
    repeat (2 * TK + 8) @(posedge i_clk);
    chk("trip", 32'h1, trip);
    apb(0, `EFP_A_STATUS, 32'h0); chk("status_trip", 32'h64b, rd);
    fault <= 0;
    repeat (8) @(posedge i_clk);
    chk("released", 32'h0, {start, trip});
    apb(0, `EFP_A_RECCUR, 32'h0); chk("rec_current", 32'h000000c8, rd);
    apb(0, `EFP_A_RECINFO, 32'h0); chk("rec_info", 32'h00000164, rd);
  endtask
  task automatic t_intrmt(input logic [31:0] it, input logic ex);
    apb(1, `EFP_A_INTRMT, it);
    repeat (5 * TK) @(posedge i_clk);
    trip_seen <= 0;
    start_seen <= 0;
    repeat (2) begin
      fault <= 1;
      repeat (2 * TK) @(posedge i_clk);
      fault <= 0;
      repeat (TK) @(posedge i_clk);
    end
    chk("short_start", 32'h1, start_seen);
    chk("intermittent", ex, trip_seen);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 0;
    t_reset();
    t_lock();
    t_sub();
    t_trip();
    t_intrmt(32'h0, 1'b0);
    t_intrmt(32'h5, 1'b1);
    complete_run();
  end
endmodule // test_earth_fault_protection_stage
